/* ctil_pkg.sv */
// constants, register map and carrier types of the cutter input command logic
package ctil_pkg;
  // ************************************************
  // register bus
  // ************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_ROUTE = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_SERIAL = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CUTLEN = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_LENCNT = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_CUTCNT = 8'h18;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ctil_bus_req_t;

  // ************************************************
  // logical commands and terminal routing
  // ************************************************
  localparam int NUM_CMD = 5;
  localparam int CMD_IMMCUT = 0;
  localparam int CMD_STARTSTOP = 1;
  localparam int CMD_CTRLEN = 2;
  localparam int CMD_JOGFWD = 3;
  localparam int CMD_JOGREV = 4;
  localparam int NUM_PIN = 8;
  localparam int PIN_PRINTMARK = 0;
  localparam int PIN_CUTPULSE = 1;
  localparam int ROUTE_W = 3;
  localparam int ROUTE_ALL_W = NUM_CMD * ROUTE_W;
  localparam logic [ROUTE_W-1:0] ROUTE_NONE = 3'h0;
  localparam logic [ROUTE_W-1:0] ROUTE_FAST3 = 3'h1;
  localparam logic [ROUTE_W-1:0] ROUTE_FAST4 = 3'h2;
  localparam logic [ROUTE_W-1:0] ROUTE_CTRL1 = 3'h3;
  localparam logic [ROUTE_W-1:0] ROUTE_CTRL2 = 3'h4;
  localparam logic [ROUTE_W-1:0] ROUTE_CTRL3 = 3'h5;
  localparam logic [ROUTE_W-1:0] ROUTE_CTRL4 = 3'h6;
  localparam logic [ROUTE_ALL_W-1:0] ROUTE_RST =
    {ROUTE_CTRL3, ROUTE_CTRL2, ROUTE_CTRL1, ROUTE_FAST4, ROUTE_FAST3};
  localparam logic [NUM_CMD-1:0] SERIAL_RST = {2'h0,
    ROUTE_RST[CMD_CTRLEN*ROUTE_W +: ROUTE_W] == ROUTE_NONE, 2'h0};

  // ************************************************
  // configuration and status fields
  // ************************************************
  localparam int CFG_INDEX_BIT = 0;
  localparam int CFG_MODE_BIT = 1;
  localparam logic [1:0] CFG_RST = 2'h0;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CUTLEN_RST = 16'h03E8;
  localparam int STAT_CMD_LSB = 0;
  localparam int STAT_HW_LSB = 5;
  localparam int STAT_RUN_BIT = 10;
  localparam int STAT_CUT_BIT = 11;
  localparam int STAT_EN_BIT = 12;
endpackage : ctil_pkg

/* ctil_sync.sv */
// two-flop synchroniser with rising edge detect for a vector of pins
`timescale 1ns/1ps
`default_nettype none
module ctil_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] levelOut,
  output logic [W-1:0] riseOut
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= pinIn;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign levelOut = sync_reg;
  assign riseOut = sync_reg & ~prev_reg;
endmodule : ctil_sync
`default_nettype wire

/* ctil_cutter_cmd.sv */
// input command logic of the rotary cutter: merge, route and apply commands
// How it works
// - each assignable command is routed to fast in 3-4, control in 1-4 or to no terminal
// - serial link may switch every command, routed to a terminal or not
// - a command is on when terminal, serial or fieldbus source is on
// - static commands act by level, dynamic ones on combined rising edge
// - index pulse per cut from remote sensor or encoder marker, by config
// - at standstill an immediate-cut rising edge starts a cut at once
// - after an immediate cut the next cut uses preset length again
// - start/stop off holds position, still allows jog and immediate cut
// - start/stop on cuts automatically by length preset or print mark
// - control enable off disables outputs and holds counters in reset
// - control enable not routed to a terminal is set on at power-up
`timescale 1ns/1ps
`default_nettype none
module ctil_cutter_cmd #(
  parameter int LEN_W = ctil_pkg::CNT_W
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire ctil_pkg::ctil_bus_req_t busReq,
  output logic [ctil_pkg::DATA_W-1:0] busRdata,
  input wire logic [3:0] fastIn,
  input wire logic [3:0] ctrlIn,
  input wire logic markerIn,
  input wire logic [ctil_pkg::NUM_CMD-1:0] fieldbusReq,
  input wire logic lineStep,
  input wire logic rollStandstill,
  output logic cutStart,
  output logic cutBusy,
  output logic autoRun,
  output logic holdPosition,
  output logic jogFwdOut,
  output logic jogRevOut,
  output logic outputsEnable,
  output logic counterReset
);
  // ************************************************
  // terminal synchronisation
  // ************************************************
  logic [ctil_pkg::NUM_PIN-1:0] pinRaw;
  logic [ctil_pkg::NUM_PIN-1:0] pinLevel;
  logic [ctil_pkg::NUM_PIN-1:0] pinRise;
  logic markerRise;

  assign pinRaw = {ctrlIn, fastIn};

  ctil_sync #(.W(ctil_pkg::NUM_PIN)) u_pin_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .pinIn(pinRaw),
    .levelOut(pinLevel),
    .riseOut(pinRise)
  );

  ctil_sync #(.W(1)) u_marker_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .pinIn(markerIn),
    .levelOut(),
    .riseOut(markerRise)
  );

  // ************************************************
  // registers
  // ************************************************
  logic [ctil_pkg::ROUTE_ALL_W-1:0] route_reg;
  logic [ctil_pkg::NUM_CMD-1:0] serial_reg;
  logic [1:0] config_reg;
  logic [LEN_W-1:0] cutLen_reg;
  logic [LEN_W-1:0] lenCount_reg;
  logic [LEN_W-1:0] lenCount_next;
  logic [ctil_pkg::CNT_W-1:0] cutCount_reg;
  logic [ctil_pkg::CNT_W-1:0] cutCount_next;
  logic [ctil_pkg::NUM_CMD-1:0] cmdPrev_reg;
  logic [ctil_pkg::DATA_W-1:0] rdata_reg;
  logic cutStart_reg;

  // ************************************************
  // routing and merge
  // ************************************************
  // pick one terminal level for a route code; unknown codes give no terminal
  function automatic logic pickPin(
    input logic [ctil_pkg::ROUTE_W-1:0] sel,
    input logic [ctil_pkg::NUM_PIN-1:0] pins
  );
    logic v;
    v = 1'b0;
    case (sel)
      ctil_pkg::ROUTE_FAST3: v = pins[2];
      ctil_pkg::ROUTE_FAST4: v = pins[3];
      ctil_pkg::ROUTE_CTRL1: v = pins[4];
      ctil_pkg::ROUTE_CTRL2: v = pins[5];
      ctil_pkg::ROUTE_CTRL3: v = pins[6];
      ctil_pkg::ROUTE_CTRL4: v = pins[7];
      default: v = 1'b0;
    endcase
    return v;
  endfunction : pickPin

  logic [ctil_pkg::NUM_CMD-1:0] hwColumn;
  logic [ctil_pkg::NUM_CMD-1:0] cmdLevel;
  logic [ctil_pkg::NUM_CMD-1:0] cmdRise;

  for (genvar c = 0; c < ctil_pkg::NUM_CMD; c++) begin : g_route
    assign hwColumn[c] =
      pickPin(route_reg[c*ctil_pkg::ROUTE_W +: ctil_pkg::ROUTE_W], pinLevel);
  end

  // serial bits count even with a terminal assigned
  assign cmdLevel = hwColumn | serial_reg | fieldbusReq;
  // edge of the merged level, so overlapping sources give one event
  assign cmdRise = cmdLevel & ~cmdPrev_reg;

  // ************************************************
  // command meaning
  // ************************************************
  logic ctrlEnable;
  logic startStop;
  logic immCutEdge;
  logic indexPulse;
  logic printMarkEdge;
  logic modePrint;
  logic lenReached;

  // static commands by level, immediate cut by edge
  assign ctrlEnable = cmdLevel[ctil_pkg::CMD_CTRLEN];
  assign startStop = cmdLevel[ctil_pkg::CMD_STARTSTOP];
  assign immCutEdge = cmdRise[ctil_pkg::CMD_IMMCUT];
  // the unselected index source is ignored and cannot end a cut
  assign indexPulse = config_reg[ctil_pkg::CFG_INDEX_BIT] ?
    markerRise : pinRise[ctil_pkg::PIN_CUTPULSE];
  assign printMarkEdge = pinRise[ctil_pkg::PIN_PRINTMARK];
  assign modePrint = config_reg[ctil_pkg::CFG_MODE_BIT];
  // the step that completes the preset length fires the cut
  assign lenReached = lineStep && (lenCount_reg >= cutLen_reg - LEN_W'(1));

  // ************************************************
  // cutting state
  // ************************************************
  typedef enum logic [1:0] {
    ST_OFF,
    ST_HOLD,
    ST_RUN,
    ST_CUT
  } ctil_state_t;

  ctil_state_t state_reg;
  ctil_state_t state_next;
  logic autoCut;
  logic manualCut;
  logic cutGo;

  // the home position before start is the operator's job, not checked here
  assign autoCut = startStop &&
    (modePrint ? printMarkEdge : lenReached);
  // a turning roll refuses the immediate cut
  assign manualCut = immCutEdge && rollStandstill;
  // requests while cutting or disabled are dropped, never queued
  assign cutGo = ctrlEnable && (state_reg != ST_CUT) &&
    (state_reg != ST_OFF) && (autoCut || manualCut);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (ctrlEnable) begin
          state_next = startStop ? ST_RUN : ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cutGo) begin
          state_next = ST_CUT;
        end else if (startStop) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (cutGo) begin
          state_next = ST_CUT;
        end else if (!startStop) begin
          state_next = ST_HOLD;
        end
      end
      ST_CUT: begin
        // a cut ends when the knife passes the index point
        if (indexPulse) begin
          state_next = startStop ? ST_RUN : ST_HOLD;
        end
      end
      default: state_next = ST_OFF;
    endcase
    if (!ctrlEnable) begin
      state_next = ST_OFF;
    end
  end

  // length progress restarts on every cut, so after a manual cut
  // the following one is again the preset length
  always_comb begin
    lenCount_next = lenCount_reg;
    if (!ctrlEnable || cutGo) begin
      lenCount_next = '0;
    end else if (lineStep && startStop && !modePrint) begin
      lenCount_next = lenCount_reg + LEN_W'(1);
    end
  end

  // cut tally wraps silently; software takes differences
  always_comb begin
    cutCount_next = cutCount_reg;
    if (!ctrlEnable) begin
      cutCount_next = '0;
    end else if (cutGo) begin
      cutCount_next = cutCount_reg + ctil_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= ST_OFF;
      lenCount_reg <= '0;
      cutCount_reg <= '0;
      cmdPrev_reg <= '0;
      cutStart_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      lenCount_reg <= lenCount_next;
      cutCount_reg <= cutCount_next;
      cmdPrev_reg <= cmdLevel;
      cutStart_reg <= cutGo;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  logic autoRun_reg;
  logic hold_reg;
  logic jogFwd_reg;
  logic jogRev_reg;
  logic enable_reg;

  // jog is only a standstill move; in automatic mode it is trim elsewhere
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      autoRun_reg <= 1'b0;
      hold_reg <= 1'b0;
      jogFwd_reg <= 1'b0;
      jogRev_reg <= 1'b0;
      enable_reg <= 1'b0;
    end else begin
      autoRun_reg <= (state_next == ST_RUN) || (state_next == ST_CUT && startStop);
      hold_reg <= (state_next == ST_HOLD);
      jogFwd_reg <= (state_next == ST_HOLD) && cmdLevel[ctil_pkg::CMD_JOGFWD];
      jogRev_reg <= (state_next == ST_HOLD) && cmdLevel[ctil_pkg::CMD_JOGREV];
      enable_reg <= ctrlEnable;
    end
  end

  assign cutStart = cutStart_reg;
  // busy straight from the state so it lines up with cutStart
  assign cutBusy = (state_reg == ST_CUT);
  assign autoRun = autoRun_reg;
  assign holdPosition = hold_reg;
  assign jogFwdOut = jogFwd_reg;
  assign jogRevOut = jogRev_reg;
  assign outputsEnable = enable_reg;
  assign counterReset = ~enable_reg;

  // ************************************************
  // register bus slave
  // ************************************************
  logic wrRoute;
  logic wrSerial;
  logic wrConfig;
  logic wrCutLen;
  logic [ctil_pkg::DATA_W-1:0] statusWord;
  logic [ctil_pkg::DATA_W-1:0] readMux;

  assign wrRoute = busReq.wr && (busReq.addr == ctil_pkg::ADDR_ROUTE);
  assign wrSerial = busReq.wr && (busReq.addr == ctil_pkg::ADDR_SERIAL);
  assign wrConfig = busReq.wr && (busReq.addr == ctil_pkg::ADDR_CONFIG);
  assign wrCutLen = busReq.wr && (busReq.addr == ctil_pkg::ADDR_CUTLEN);

  always_comb begin
    statusWord = '0;
    statusWord[ctil_pkg::STAT_CMD_LSB +: ctil_pkg::NUM_CMD] = cmdLevel;
    statusWord[ctil_pkg::STAT_HW_LSB +: ctil_pkg::NUM_CMD] = hwColumn;
    statusWord[ctil_pkg::STAT_RUN_BIT] = autoRun_reg;
    statusWord[ctil_pkg::STAT_CUT_BIT] = cutBusy;
    statusWord[ctil_pkg::STAT_EN_BIT] = enable_reg;
  end

  // unmapped addresses read as zero; writes there are dropped
  assign readMux =
    (busReq.addr == ctil_pkg::ADDR_ROUTE) ?
      ctil_pkg::DATA_W'(route_reg) :
    (busReq.addr == ctil_pkg::ADDR_SERIAL) ?
      ctil_pkg::DATA_W'(serial_reg) :
    (busReq.addr == ctil_pkg::ADDR_CONFIG) ?
      ctil_pkg::DATA_W'(config_reg) :
    (busReq.addr == ctil_pkg::ADDR_CUTLEN) ?
      ctil_pkg::DATA_W'(cutLen_reg) :
    (busReq.addr == ctil_pkg::ADDR_STATUS) ? statusWord :
    (busReq.addr == ctil_pkg::ADDR_LENCNT) ?
      ctil_pkg::DATA_W'(lenCount_reg) :
    (busReq.addr == ctil_pkg::ADDR_CUTCNT) ?
      ctil_pkg::DATA_W'(cutCount_reg) :
    '0;

  // serial enable bit comes up set when no terminal carries the enable
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      route_reg <= ctil_pkg::ROUTE_RST;
      serial_reg <= ctil_pkg::SERIAL_RST;
      config_reg <= ctil_pkg::CFG_RST;
      cutLen_reg <= LEN_W'(ctil_pkg::CUTLEN_RST);
      rdata_reg <= '0;
    end else begin
      if (wrRoute) begin
        route_reg <= busReq.wdata[ctil_pkg::ROUTE_ALL_W-1:0];
      end
      if (wrSerial) begin
        serial_reg <= busReq.wdata[ctil_pkg::NUM_CMD-1:0];
      end
      if (wrConfig) begin
        config_reg <= busReq.wdata[1:0];
      end
      if (wrCutLen) begin
        cutLen_reg <= busReq.wdata[LEN_W-1:0];
      end
      // zero outside the read slot, so several slaves can be ORed
      rdata_reg <= busReq.rd ? readMux : '0;
    end
  end

  assign busRdata = rdata_reg;
endmodule : ctil_cutter_cmd
`default_nettype wire

/* ctil_sensor_model.sv */
// machine sensor model: index pulse source behind the cutting roll
`timescale 1ns/1ps
`default_nettype none
module ctil_sensor_model #(
  parameter int DLY = 6
) (
  input wire logic ref_clk,
  input wire logic cutStart,
  input wire logic useMarker,
  output logic cutPulse,
  output logic markerPulse
);
  // ****************
  // index pulse
  // ****************
  int cnt = 0;
  // one index pulse per cut, knife reaches the sensor some cycles later
  always @(posedge ref_clk) begin
    if (cutStart === 1'b1) cnt <= DLY;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  // only the configured source pulses, so a wrong select leaves the cut hanging
  assign cutPulse = !useMarker && (cnt inside {[1:3]});
  assign markerPulse = useMarker && (cnt inside {[1:3]});
endmodule : ctil_sensor_model
`default_nettype wire

/* ctil_cutter_cmd_monitor.sv */
// port checker of the cutter input command logic
`timescale 1ns/1ps
`default_nettype none
module ctil_cutter_cmd_monitor (
  input wire logic ref_clk,
  input wire logic reset,
  input wire ctil_pkg::ctil_bus_req_t busReq,
  input wire logic [31:0] busRdata,
  input wire logic [3:0] fastIn,
  input wire logic [3:0] ctrlIn,
  input wire logic markerIn,
  input wire logic [4:0] fieldbusReq,
  input wire logic lineStep,
  input wire logic rollStandstill,
  input wire logic cutStart,
  input wire logic cutBusy,
  input wire logic autoRun,
  input wire logic holdPosition,
  input wire logic jogFwdOut,
  input wire logic jogRevOut,
  input wire logic outputsEnable,
  input wire logic counterReset
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  sequence s_cutHead;
    cutBusy ##1 (cutBusy && !cutStart);
  endsequence
  property p_cutStart;
    cutStart |-> s_cutHead;
  endproperty
  a_cutStart: assert property (p_cutStart)
    else $error("cut pulse without busy phase");
  // fieldbus shares the clock, so no synchroniser lag here
  property p_immCut;
    holdPosition && rollStandstill && $rose(fieldbusReq[0]) && !fastIn[2] |=> cutStart && cutBusy;
  endproperty
  a_immCut: assert property (p_immCut)
    else $error("immediate cut not started");
  property p_fbEnable;
    !$past(reset) && fieldbusReq[2] |=> outputsEnable;
  endproperty
  a_fbEnable: assert property (p_fbEnable)
    else $error("fieldbus enable ignored");
  property p_run;
    holdPosition && fieldbusReq[1] && fieldbusReq[2] |=> autoRun;
  endproperty
  a_run: assert property (p_run)
    else $error("start did not begin automatic run");
  property p_hold;
    holdPosition |-> !autoRun && !cutBusy;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold overlaps run or cut");
  property p_jog;
    jogFwdOut || jogRevOut |-> holdPosition;
  endproperty
  a_jog: assert property (p_jog)
    else $error("jog outside hold");
  property p_off;
    !outputsEnable |-> !(autoRun || holdPosition || cutBusy || cutStart);
  endproperty
  a_off: assert property (p_off)
    else $error("activity while disabled");
  property p_cntRst;
    counterReset != outputsEnable;
  endproperty
  a_cntRst: assert property (p_cntRst)
    else $error("counter reset not inverse of enable");
  property p_rdIdle;
    !busReq.rd |=> busRdata == 32'h0;
  endproperty
  a_rdIdle: assert property (p_rdIdle)
    else $error("read data outside read slot");
endmodule : ctil_cutter_cmd_monitor
`default_nettype wire

/* test_ctil_cutter_cmd.sv */
// testbench of the cutter input command logic
`timescale 1ns/1ps
`default_nettype none
module test_ctil_cutter_cmd;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  ctil_pkg::ctil_bus_req_t busReq = '0;
  logic [31:0] busRdata;
  logic [5:0] hwPins = 6'h0;
  logic [4:0] fieldbusReq = 5'h0;
  logic printMark = 1'b0;
  logic lineStep = 1'b0;
  logic rollStandstill = 1'b1;
  logic useMarker = 1'b0;
  logic cutPulse, markerPulse, cutStart, cutBusy, autoRun, holdPosition;
  logic jogFwdOut, jogRevOut, outputsEnable, counterReset;
  int errorCnt = 0;
  int comparisons = 0;
  int cuts = 0;
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (cutStart === 1'b1) cuts <= cuts + 1;
  end
  ctil_cutter_cmd ctil_cutter_cmd_inst (
    .ref_clk, .reset, .busReq, .busRdata, .fastIn({hwPins[1:0], cutPulse, printMark}),
    .ctrlIn(hwPins[5:2]), .markerIn(markerPulse), .fieldbusReq, .lineStep, .rollStandstill,
    .cutStart, .cutBusy, .autoRun, .holdPosition, .jogFwdOut, .jogRevOut, .outputsEnable,
    .counterReset
  );
  ctil_sensor_model ctil_sensor_model_inst (
    .ref_clk, .cutStart, .useMarker, .cutPulse, .markerPulse
  );
  // ****************
  // tasks
  // ****************
  task automatic completeRun;
    if (errorCnt == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : completeRun
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errorCnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  // trailing idle cycle keeps two writes from touching the strobe in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    busReq.addr <= a;
    busReq.wdata <= d;
    busReq.wr <= 1'b1;
    tick(1);
    busReq.wr <= 1'b0;
    tick(1);
  endtask : wr
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
    busReq.addr <= a;
    busReq.rd <= 1'b1;
    tick(1);
    busReq.rd <= 1'b0;
    tick(1);
    chk(what, busRdata, exp);
  endtask : rdChk
  task automatic step;
    lineStep <= 1'b1;
    tick(1);
    lineStep <= 1'b0;
    tick(1);
  endtask : step
  task automatic waitIdle;
    for (int n = 0; n < 40 && cutBusy !== 1'b0; n++) tick(1);
    if (cutBusy !== 1'b0) begin
      errorCnt++;
      completeRun();
    end
  endtask : waitIdle
  // ****************
  // sequence
  // ****************
  initial begin
    tick(8);
    reset <= 1'b0;
    tick(2);
    rdChk(ctil_pkg::ADDR_ROUTE, 32'(ctil_pkg::ROUTE_RST), "route");
    rdChk(ctil_pkg::ADDR_SERIAL, 32'(ctil_pkg::SERIAL_RST), "serial");
    rdChk(ctil_pkg::ADDR_CONFIG, 32'h0, "config");
    rdChk(ctil_pkg::ADDR_CUTLEN, 32'(ctil_pkg::CUTLEN_RST), "cutlen");
    wr(8'hFC, 32'hFFFFFFFF);
    rdChk(8'hFC, 32'h0, "unmapped");
    chk("enable", outputsEnable, 32'h0);
    for (int c = 1; c < 8; c++) begin
      wr(ctil_pkg::ADDR_ROUTE, 32'(ctil_pkg::ROUTE_RST) & 32'hFFFFFE3F | (32'(c) << 6));
      hwPins <= (c == 7) ? 6'h3F : 6'h1 << (c - 1);
      tick(5);
      chk("routed on", outputsEnable, 32'(c < 7));
      hwPins <= 6'h0;
      tick(5);
      chk("routed off", counterReset, 32'h1);
    end
    wr(ctil_pkg::ADDR_ROUTE, 32'(ctil_pkg::ROUTE_RST));
    fieldbusReq <= 5'h04;
    tick(3);
    chk("hold", holdPosition, 32'h1);
    rdChk(ctil_pkg::ADDR_STATUS, 32'h1004, "status");
    fieldbusReq <= 5'h0C;
    tick(2);
    chk("jog fwd", jogFwdOut, 32'h1);
    fieldbusReq <= 5'h14;
    tick(2);
    chk("jog rev", {jogFwdOut, jogRevOut}, 32'h1);
    rollStandstill <= 1'b0;
    fieldbusReq <= 5'h05;
    tick(2);
    chk("moving cut", {cutStart, cutBusy}, 32'h0);
    rollStandstill <= 1'b1;
    fieldbusReq <= 5'h04;
    tick(1);
    fieldbusReq <= 5'h05;
    tick(2);
    chk("imm cut", {cutStart, cutBusy, holdPosition}, 32'h6);
    waitIdle();
    tick(6);
    chk("held cut count", cuts, 32'h1);
    wr(ctil_pkg::ADDR_CUTLEN, 32'h5);
    fieldbusReq <= 5'h06; // start only with the knife back at its index
    tick(2);
    chk("auto run", {autoRun, holdPosition}, 32'h2);
    repeat (2) step();
    rdChk(ctil_pkg::ADDR_LENCNT, 32'h2, "length count");
    hwPins <= 6'h1;
    tick(8);
    hwPins <= 6'h0;
    chk("pin cut count", cuts, 32'h2);
    waitIdle();
    for (int i = 1; i < 6; i++) begin
      step();
      chk("length cut", cutStart, 32'(i == 5));
    end
    waitIdle();
    wr(ctil_pkg::ADDR_CONFIG, 32'h3);
    useMarker <= 1'b1;
    printMark <= 1'b1;
    tick(3);
    printMark <= 1'b0;
    tick(3);
    chk("mark cut", cuts, 32'h4);
    waitIdle();
    rdChk(ctil_pkg::ADDR_CUTCNT, 32'h4, "cut tally");
    fieldbusReq <= 5'h0;
    tick(2);
    chk("disabled", {outputsEnable, autoRun, counterReset}, 32'h1);
    rdChk(ctil_pkg::ADDR_CUTCNT, 32'h0, "cut counter");
    wr(ctil_pkg::ADDR_SERIAL, 32'h4);
    tick(1);
    chk("serial enable", outputsEnable, 32'h1);
    completeRun();
  end
endmodule : test_ctil_cutter_cmd
bind ctil_cutter_cmd ctil_cutter_cmd_monitor ctil_cutter_cmd_monitor_inst (
  .ref_clk, .reset, .busReq, .busRdata, .fastIn, .ctrlIn, .markerIn, .fieldbusReq,
  .lineStep, .rollStandstill, .cutStart, .cutBusy, .autoRun, .holdPosition, .jogFwdOut,
  .jogRevOut, .outputsEnable, .counterReset
);
`default_nettype wire
